// File: smsi_pkg.sv
package smsi_pkg;

   localparam int SMSI_NUM_CH = 2;
   localparam int SMSI_AW     = 8;

   // Register byte offsets
   localparam logic [7:0] SMSI_OFF_STAT0 = 8'h00;
   localparam logic [7:0] SMSI_OFF_STAT1 = 8'h04;
   localparam logic [7:0] SMSI_OFF_MSIEN = 8'h08;
   localparam logic [7:0] SMSI_OFF_ISTAT = 8'h0C;
   localparam logic [7:0] SMSI_OFF_IMASK = 8'h10;

   // Field positions of modem_line_status
   localparam int SMSI_BIT_CTS_CHG = 0;
   localparam int SMSI_BIT_SR_CHG  = 1;
   localparam int SMSI_BIT_CD_CHG  = 3;
   localparam int SMSI_BIT_CTS     = 4;
   localparam int SMSI_BIT_SR      = 5;
   localparam int SMSI_BIT_CD      = 7;

   // Position of each modem input in a channel's pin vector
   localparam int SMSI_IN_CTS = 0;
   localparam int SMSI_IN_SR  = 1;
   localparam int SMSI_IN_CD  = 2;
   localparam int SMSI_NUM_IN = 3;

   // Reset values
   localparam logic [1:0] SMSI_RST_MSIEN = 2'h0;
   localparam logic [1:0] SMSI_RST_IMASK = 2'h0;
   localparam logic [1:0] SMSI_RST_ISTAT = 2'h0;
   localparam logic       SMSI_RST_PIN   = 1'h1;

   localparam logic [1:0] SMSI_RESP_OKAY   = 2'h0;
   localparam logic [1:0] SMSI_RESP_SLVERR = 2'h2;

   typedef enum {
      SMSI_REG_STAT0,
      SMSI_REG_STAT1,
      SMSI_REG_MSIEN,
      SMSI_REG_ISTAT,
      SMSI_REG_IMASK,
      SMSI_REG_NONE
   } smsi_reg_e;

   function automatic smsi_reg_e smsi_decode(input logic [7:0] addr);
      case (addr)
         SMSI_OFF_STAT0: smsi_decode = SMSI_REG_STAT0;
         SMSI_OFF_STAT1: smsi_decode = SMSI_REG_STAT1;
         SMSI_OFF_MSIEN: smsi_decode = SMSI_REG_MSIEN;
         SMSI_OFF_ISTAT: smsi_decode = SMSI_REG_ISTAT;
         SMSI_OFF_IMASK: smsi_decode = SMSI_REG_IMASK;
         default:        smsi_decode = SMSI_REG_NONE;
      endcase
   endfunction

endpackage

// File: smsi_sync.sv
`timescale 1ns/1ps

module smsi_sync
   import smsi_pkg::*;
#(
   parameter int W = 6
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_q;

   // Idle modem lines sit high, so reset to high avoids a false change
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= {W{SMSI_RST_PIN}};
         q      <= {W{SMSI_RST_PIN}};
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

   sync_delay_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) && $past(aresetn, 2) |-> q == $past(d, 2))
      else $error("synchroniser output does not follow input after two edges");

endmodule

// File: smsi_chan.sv
`timescale 1ns/1ps

module smsi_chan
   import smsi_pkg::*;
(
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic [SMSI_NUM_IN-1:0] lvl_n,
   input  wire logic                   rd_clr,
   output logic      [7:0]             stat,
   output logic                        chg_evt
);

   logic [SMSI_NUM_IN-1:0] lvl_q;
   logic [SMSI_NUM_IN-1:0] chg;
   logic [SMSI_NUM_IN-1:0] flag_q;

   assign chg = lvl_n ^ lvl_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lvl_q <= {SMSI_NUM_IN{SMSI_RST_PIN}};
      end else begin
         lvl_q <= lvl_n;
      end
   end

   // A change seen in the clearing cycle survives the read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_q <= '0;
      end else begin
         flag_q <= (flag_q & ~{SMSI_NUM_IN{rd_clr}}) | chg;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         chg_evt <= 1'b0;
      end else begin
         chg_evt <= |chg;
      end
   end

   // Levels only feed status; nothing here reaches a transmitter
   always_comb begin
      stat                   = 8'h00;
      stat[SMSI_BIT_CTS]     = ~lvl_q[SMSI_IN_CTS];
      stat[SMSI_BIT_SR]      = ~lvl_q[SMSI_IN_SR];
      stat[SMSI_BIT_CD]      = ~lvl_q[SMSI_IN_CD];
      stat[SMSI_BIT_CTS_CHG] = flag_q[SMSI_IN_CTS];
      stat[SMSI_BIT_SR_CHG]  = flag_q[SMSI_IN_SR];
      stat[SMSI_BIT_CD_CHG]  = flag_q[SMSI_IN_CD];
   end

   cts_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> stat[SMSI_BIT_CTS] == !$past(lvl_n[SMSI_IN_CTS]))
      else $error("clear-to-send status bit is not the inverted input");

   sr_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> stat[SMSI_BIT_SR] == !$past(lvl_n[SMSI_IN_SR]))
      else $error("set-ready status bit is not the inverted input");

   cd_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> stat[SMSI_BIT_CD] == !$past(lvl_n[SMSI_IN_CD]))
      else $error("carrier-detect status bit is not the inverted input");

   cts_change_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) && $past(aresetn, 2) && $past(lvl_n[SMSI_IN_CTS]) != $past(lvl_n[SMSI_IN_CTS], 2)
      |-> stat[SMSI_BIT_CTS_CHG])
      else $error("clear-to-send change not flagged");

   sr_change_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) && $past(aresetn, 2) && $past(lvl_n[SMSI_IN_SR]) != $past(lvl_n[SMSI_IN_SR], 2)
      |-> stat[SMSI_BIT_SR_CHG])
      else $error("set-ready change not flagged");

   cd_change_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) && $past(aresetn, 2) && $past(lvl_n[SMSI_IN_CD]) != $past(lvl_n[SMSI_IN_CD], 2)
      |-> stat[SMSI_BIT_CD_CHG])
      else $error("carrier-detect change not flagged");

   read_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(rd_clr) && $past(chg) == '0 |-> flag_q == '0)
      else $error("change flags not cleared by status read");

endmodule

// File: smsi_top.sv
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps

// Overview of operation
// - Status bit 4 is inverted clear-to-send
// - Bit 0 flags clear-to-send change since read
// - Clear-to-send change interrupts when enabled
// - Clear-to-send never alters transmitter operation
// - Status bit 7 is inverted carrier-detect
// - Bit 3 flags carrier-detect change since read
// - Carrier-detect change interrupts when enabled
// - Each channel keeps its own flags
// - Status bit 5 is inverted set-ready
// - Bit 1 flags set-ready change, interrupts
module smsi_top
   import smsi_pkg::*;
(
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic [SMSI_AW-1:0]     s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic      [1:0]             s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [SMSI_AW-1:0]     s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic      [31:0]            s_axi_rdata,
   output logic      [1:0]             s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   input  wire logic [SMSI_NUM_CH-1:0] cts_n,
   input  wire logic [SMSI_NUM_CH-1:0] sr_n,
   input  wire logic [SMSI_NUM_CH-1:0] cd_n,
   output logic      [SMSI_NUM_CH-1:0] chan_irq,
   output logic                        irq
);

   ////////////////////////////////////////////////////////////////////////

   localparam int PW = SMSI_NUM_CH * SMSI_NUM_IN;

   logic [PW-1:0]          pins_raw;
   logic [PW-1:0]          pins_sync;
   logic [7:0]             chan_stat [SMSI_NUM_CH];
   logic [SMSI_NUM_CH-1:0] chan_evt;
   logic [SMSI_NUM_CH-1:0] flag_any;
   logic [SMSI_NUM_CH-1:0] rd_clr;

   logic                   aw_full_q;
   logic [SMSI_AW-1:0]     aw_addr_q;
   logic                   w_full_q;
   logic [7:0]             w_data_q;
   logic                   w_lane0_q;
   logic                   aw_take;
   logic                   w_take;
   logic                   do_write;
   logic                   rd_take;
   smsi_reg_e              wr_sel;
   smsi_reg_e              rd_sel;
   logic [31:0]            rd_word;

   logic [1:0]             msi_en_q;
   logic [1:0]             int_status_q;
   logic [1:0]             int_mask_q;
   logic [1:0]             istat_clr;

   ////////////////////////////////////////////////////////////////////////
   // Modem inputs idle high; reset of the synchroniser matches that

   genvar gi;
   generate
      for (gi = 0; gi < SMSI_NUM_CH; gi++) begin : g_pins
         assign pins_raw[gi*SMSI_NUM_IN + SMSI_IN_CTS] = cts_n[gi];
         assign pins_raw[gi*SMSI_NUM_IN + SMSI_IN_SR]  = sr_n[gi];
         assign pins_raw[gi*SMSI_NUM_IN + SMSI_IN_CD]  = cd_n[gi];
      end
   endgenerate

   smsi_sync #(
      .W (PW)
   ) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       (pins_raw),
      .q       (pins_sync)
   );

   ////////////////////////////////////////////////////////////////////////
   // One independent status channel per serial port

   generate
      for (gi = 0; gi < SMSI_NUM_CH; gi++) begin : g_chan
         smsi_chan u_chan (
            .aclk    (aclk),
            .aresetn (aresetn),
            .lvl_n   (pins_sync[gi*SMSI_NUM_IN +: SMSI_NUM_IN]),
            .rd_clr  (rd_clr[gi]),
            .stat    (chan_stat[gi]),
            .chg_evt (chan_evt[gi])
         );

         assign flag_any[gi] = chan_stat[gi][SMSI_BIT_CTS_CHG]
                             | chan_stat[gi][SMSI_BIT_SR_CHG]
                             | chan_stat[gi][SMSI_BIT_CD_CHG];

         assign rd_clr[gi] = rd_take &&
            (rd_sel == ((gi == 0) ? SMSI_REG_STAT0 : SMSI_REG_STAT1));
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Write address and data are taken independently, in any order

   assign aw_take  = s_axi_awvalid && s_axi_awready;
   assign w_take   = s_axi_wvalid && s_axi_wready;
   assign do_write = aw_full_q && w_full_q && !s_axi_bvalid;
   assign wr_sel   = smsi_decode(aw_addr_q);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q     <= 1'b0;
         aw_addr_q     <= '0;
         s_axi_awready <= 1'b0;
      end else if (aw_take) begin
         aw_full_q     <= 1'b1;
         aw_addr_q     <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else begin
         if (do_write) begin
            aw_full_q <= 1'b0;
         end
         s_axi_awready <= do_write || !aw_full_q;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full_q     <= 1'b0;
         w_data_q     <= 8'h00;
         w_lane0_q    <= 1'b0;
         s_axi_wready <= 1'b0;
      end else if (w_take) begin
         w_full_q     <= 1'b1;
         w_data_q     <= s_axi_wdata[7:0];
         w_lane0_q    <= s_axi_wstrb[0];
         s_axi_wready <= 1'b0;
      end else begin
         if (do_write) begin
            w_full_q <= 1'b0;
         end
         s_axi_wready <= do_write || !w_full_q;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= SMSI_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (wr_sel == SMSI_REG_NONE) ? SMSI_RESP_SLVERR : SMSI_RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control registers; status words ignore writes

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         msi_en_q   <= SMSI_RST_MSIEN;
         int_mask_q <= SMSI_RST_IMASK;
      end else if (do_write && w_lane0_q) begin
         if (wr_sel == SMSI_REG_MSIEN) begin
            msi_en_q <= w_data_q[1:0];
         end
         if (wr_sel == SMSI_REG_IMASK) begin
            int_mask_q <= w_data_q[1:0];
         end
      end
   end

   assign istat_clr = (do_write && w_lane0_q && wr_sel == SMSI_REG_ISTAT)
                    ? w_data_q[1:0] : 2'h0;

   // Set beats write-one-to-clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         int_status_q <= SMSI_RST_ISTAT;
      end else begin
         int_status_q <= (int_status_q & ~istat_clr) | chan_evt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read channel: one outstanding read, answered the next edge

   assign rd_take = s_axi_arvalid && s_axi_arready;
   assign rd_sel  = smsi_decode(s_axi_araddr);

   always_comb begin
      rd_word = 32'h0000_0000;
      case (rd_sel)
         SMSI_REG_STAT0: rd_word[7:0] = chan_stat[0];
         SMSI_REG_STAT1: rd_word[7:0] = chan_stat[1];
         SMSI_REG_MSIEN: rd_word[1:0] = msi_en_q;
         SMSI_REG_ISTAT: rd_word[1:0] = int_status_q;
         SMSI_REG_IMASK: rd_word[1:0] = int_mask_q;
         default:        rd_word      = 32'h0000_0000;
      endcase
   end

   // Data is captured before the flags clear on the same edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= SMSI_RESP_OKAY;
      end else if (rd_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= (rd_sel == SMSI_REG_NONE) ? SMSI_RESP_SLVERR : SMSI_RESP_OKAY;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_arready <= !(rd_take || (s_axi_rvalid && !s_axi_rready));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupts

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         chan_irq <= '0;
      end else begin
         chan_irq <= msi_en_q & flag_any;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(int_status_q & int_mask_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////

   cts_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) && $past(msi_en_q[0]) && $past(chan_stat[0][SMSI_BIT_CTS_CHG])
      |-> chan_irq[0])
      else $error("clear-to-send change did not raise channel 0 interrupt");

   cd_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) && $past(msi_en_q[1]) && $past(chan_stat[1][SMSI_BIT_CD_CHG])
      |-> chan_irq[1])
      else $error("carrier-detect change did not raise channel 1 interrupt");

   sr_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) && $past(msi_en_q[0]) && $past(chan_stat[0][SMSI_BIT_SR_CHG])
      |-> chan_irq[0])
      else $error("set-ready change did not raise channel 0 interrupt");

   irq_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) && !$past(msi_en_q[0]) |-> !chan_irq[0])
      else $error("channel 0 interrupt raised while disabled");

   read_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
      rd_take && rd_sel == SMSI_REG_STAT0
      |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(chan_stat[0]))
      else $error("status read did not return the pre-clear value");

   irq_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (int_status_q & int_mask_q) != 2'h0 |=> irq)
      else $error("unmasked status bit did not raise irq");

   // Set must win over a clear in the same cycle
   istat_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
      chan_evt[0] |=> int_status_q[0])
      else $error("channel 0 event did not set interrupt status");

   istat_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
      istat_clr[1] && !chan_evt[1] |=> !int_status_q[1])
      else $error("write of one did not clear interrupt status");

   chan_iso_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) && $stable(pins_sync[SMSI_NUM_IN +: SMSI_NUM_IN])
      && chan_stat[1][SMSI_BIT_CD_CHG:SMSI_BIT_CTS_CHG] == 4'h0
      |=> chan_stat[1][SMSI_BIT_CD_CHG:SMSI_BIT_CTS_CHG] == 4'h0)
      else $error("channel 1 flagged a change its own inputs did not make");

endmodule

// File: smsi_modem_model.sv
`timescale 1ns/1ps

module smsi_modem_model
   import smsi_pkg::*;
(
   input  wire logic [SMSI_NUM_CH-1:0] clear_on,
   input  wire logic [SMSI_NUM_CH-1:0] ready_on,
   input  wire logic [SMSI_NUM_CH-1:0] carrier_on,
   output logic      [SMSI_NUM_CH-1:0] cts_n,
   output logic      [SMSI_NUM_CH-1:0] sr_n,
   output logic      [SMSI_NUM_CH-1:0] cd_n
);
   // Odd skew keeps pin edges away from the sampling clock edge
   assign #3 cts_n = ~clear_on;
   assign #3 sr_n  = ~ready_on;
   assign #3 cd_n  = ~carrier_on;
endmodule

// File: test_serial_modem_status_inputs.sv
`timescale 1ns/1ps

module test_serial_modem_status_inputs;
   import smsi_pkg::*;

   typedef struct packed {
      logic [1:0] clr;
      logic [1:0] rdy;
      logic [1:0] car;
      logic [7:0] e0;
      logic [7:0] e1;
   } smsi_row_s;

   logic                   aclk;
   logic                   aresetn;
   logic [SMSI_AW-1:0]     s_axi_awaddr, s_axi_araddr;
   logic [31:0]            s_axi_wdata, s_axi_rdata, d;
   logic [3:0]             s_axi_wstrb;
   logic [1:0]             s_axi_bresp, s_axi_rresp;
   logic                   s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic                   s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic                   s_axi_rvalid, s_axi_rready, irq;
   logic [SMSI_NUM_CH-1:0] cts_n, sr_n, cd_n, chan_irq, clr, rdy, car;
   smsi_row_s              rows [5];
   int                     n_errors;
   int                     n_compared;

   smsi_top smsi_top_inst (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .cts_n, .sr_n, .cd_n, .chan_irq, .irq
   );

   smsi_modem_model smsi_modem_model_inst (
      .clear_on(clr), .ready_on(rdy), .carrier_on(car), .cts_n, .sr_n, .cd_n
   );

   ////////////////////////////////////////////////////////////////////////////
   task automatic results();
      $display("compared %0d, errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic hang();
      n_errors++;
      $display("wrong value at %0t: bus answer missing", $time);
      results();
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // Entered just after a rising edge; ends one edge after the response
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = SMSI_RESP_OKAY);
      int   t;
      logic done;
      t = 0;
      done = 1'h0;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= v;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid  <= 1'h1;
      s_axi_bready  <= 1'h1;
      while (!done && t < 64) begin
         @(posedge aclk);
         t++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid && s_axi_bready) begin
            done = 1'h1;
            s_axi_bready <= 1'h0;
            check(32'(s_axi_bresp), 32'(er));
         end
      end
      if (!done) hang();
      @(posedge aclk);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er = SMSI_RESP_OKAY);
      int   t;
      logic done;
      t = 0;
      done = 1'h0;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready  <= 1'h1;
      while (!done && t < 64) begin
         @(posedge aclk);
         t++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid && s_axi_rready) begin
            done = 1'h1;
            v = s_axi_rdata;
            s_axi_rready <= 1'h0;
            check(32'(s_axi_rresp), 32'(er));
         end
      end
      if (!done) hang();
      @(posedge aclk);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      aclk = 1'h0;
      forever #5 aclk = ~aclk;
   end

   initial begin
      #50us;
      n_errors++;
      $display("wrong value at %0t: watchdog expired", $time);
      results();
   end

   initial begin
      // Change flags relative to the previous row, which was read; row 0 to the idle lines read after reset
      rows = '{'{2'h1, 2'h0, 2'h0, 8'h11, 8'h00}, '{2'h1, 2'h2, 2'h0, 8'h10, 8'h22},
               '{2'h0, 2'h2, 2'h3, 8'h89, 8'hA8}, '{2'h3, 2'h1, 2'h2, 8'h3B, 8'h93},
               '{2'h0, 2'h0, 2'h0, 8'h03, 8'h09}};
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
      {clr, rdy, car} = '0;
      aresetn = 1'h0;
      tick(8);
      aresetn <= 1'h1;
      tick(1);
      for (int a = 0; a <= 16; a += 4) begin
         rd(8'(a), d);
         check(d, 32'h0);
      end
      check(32'({chan_irq, irq}), 32'h0);
      $display("reset test done");

      wr(SMSI_OFF_MSIEN, 32'h1);
      foreach (rows[i]) begin
         clr <= rows[i].clr;
         rdy <= rows[i].rdy;
         car <= rows[i].car;
         tick(8);
         check(32'(chan_irq), {31'h0, |rows[i].e0[3:0]});
         rd(SMSI_OFF_STAT0, d);
         check(d, 32'(rows[i].e0));
         rd(SMSI_OFF_STAT1, d);
         check(d, 32'(rows[i].e1));
         rd(SMSI_OFF_STAT0, d);
         check(d, 32'(rows[i].e0 & 8'hB0));
         tick(2);
         check(32'(chan_irq), 32'h0);
         $display("row %0d done", i);
      end

      wr(SMSI_OFF_MSIEN, 32'h3);
      clr <= 2'h2;
      car <= 2'h2;
      tick(8);
      check(32'(chan_irq), 32'h2);
      rd(SMSI_OFF_STAT1, d);
      check(d, 32'h99);
      rd(SMSI_OFF_ISTAT, d);
      check(d, 32'h3);
      wr(SMSI_OFF_IMASK, 32'h3);
      tick(2);
      check(32'(irq), 32'h1);
      wr(SMSI_OFF_ISTAT, 32'h1);
      rd(SMSI_OFF_ISTAT, d);
      check(d, 32'h2);
      wr(SMSI_OFF_IMASK, 32'h1);
      tick(2);
      check(32'(irq), 32'h0);
      wr(SMSI_OFF_ISTAT, 32'h2);
      rd(SMSI_OFF_ISTAT, d);
      check(d, 32'h0);
      $display("interrupt test done");

      // Status words are read-only; unmapped space answers with an error
      wr(SMSI_OFF_STAT1, 32'hFF);
      rd(SMSI_OFF_STAT1, d);
      check(d, 32'h90);
      wr(8'h14, 32'h3, SMSI_RESP_SLVERR);
      rd(8'h14, d, SMSI_RESP_SLVERR);
      check(d, 32'h0);
      s_axi_wstrb <= 4'h0;
      wr(SMSI_OFF_MSIEN, 32'h0);
      s_axi_wstrb <= 4'hF;
      rd(SMSI_OFF_MSIEN, d);
      check(d, 32'h3);
      $display("register access test done");

      // Carrier already present when reset lifts counts as a change
      clr <= 2'h0;
      car <= 2'h1;
      aresetn <= 1'h0;
      tick(8);
      aresetn <= 1'h1;
      tick(6);
      rd(SMSI_OFF_STAT0, d);
      check(d, 32'h88);
      rd(SMSI_OFF_MSIEN, d);
      check(d, 32'h0);
      check(32'({chan_irq, irq}), 32'h0);
      $display("mid-run reset test done");
      results();
   end
endmodule
